// [src/cbsu_cond.v]
/*
 * Combinational decode and condition evaluation of one skip or branch
 * instruction, with its target program counter and cycle count.
 * Assumes all inputs are stable for the cycle in which they are used.
 */
`timescale 1ns/1ps
`include "cbsu_defs.vh"

module cbsu_cond (
    // Instruction and context
    input  wire [15:0] instr_word,
    input  wire [15:0] instr_pc,
    input  wire [7:0]  status_flags_register_in,
    input  wire [7:0]  io_rdata,
    input  wire        next_two_word,
    // Result
    output reg  [3:0]  op_class,
    output reg         taken,
    output reg  [15:0] target_pc,
    output reg  [1:0]  cycles
);

    wire [15:0] k_ext;
    wire [2:0]  sel;

    // Sign-extended displacement
    assign k_ext = {{9{instr_word[`CBSU_K_MSB]}},
                    instr_word[`CBSU_K_MSB:`CBSU_K_LSB]}; // RL13
    assign sel   = instr_word[`CBSU_S_MSB:`CBSU_S_LSB];

    function [3:0] cbsu_decode;
        input [15:0] w;
        begin
            if ((w & `CBSU_SKIP_MASK) == `CBSU_SKIP_VAL) begin
                cbsu_decode = `CBSU_OP_SKIP_IO;
            end else if ((w & `CBSU_BR_MASK) == `CBSU_BRSET_VAL) begin
                case (w[`CBSU_S_MSB:`CBSU_S_LSB]) // RL12
                    `CBSU_FLAG_Z: cbsu_decode = `CBSU_OP_EQUAL;
                    `CBSU_FLAG_C: cbsu_decode = `CBSU_OP_CARRY_SET;
                    `CBSU_FLAG_N: cbsu_decode = `CBSU_OP_MINUS;
                    default:      cbsu_decode = `CBSU_OP_FLAG_SET;
                endcase
            end else if ((w & `CBSU_BR_MASK) == `CBSU_BRCLR_VAL) begin
                case (w[`CBSU_S_MSB:`CBSU_S_LSB]) // RL12
                    `CBSU_FLAG_Z: cbsu_decode = `CBSU_OP_NOT_EQUAL;
                    `CBSU_FLAG_C: cbsu_decode = `CBSU_OP_CARRY_CLEAR;
                    `CBSU_FLAG_N: cbsu_decode = `CBSU_OP_PLUS;
                    default:      cbsu_decode = `CBSU_OP_FLAG_CLEAR;
                endcase
            end else begin
                cbsu_decode = `CBSU_OP_NONE;
            end
        end
    endfunction

    always @* begin
        op_class  = cbsu_decode(instr_word);
        taken     = 1'b0;
        target_pc = instr_pc + `CBSU_STEP_ONE;
        cycles    = `CBSU_CYC_ONE;
        case (op_class)
            `CBSU_OP_SKIP_IO: begin
                taken = io_rdata[instr_word[`CBSU_B_MSB:`CBSU_B_LSB]]; // RL1
            end
            `CBSU_OP_FLAG_SET:    taken = status_flags_register_in[sel];                 // RL2
            `CBSU_OP_FLAG_CLEAR:  taken = ~status_flags_register_in[sel];                // RL3
            `CBSU_OP_EQUAL:       taken = status_flags_register_in[`CBSU_FLAG_Z];        // RL4
            `CBSU_OP_NOT_EQUAL:   taken = ~status_flags_register_in[`CBSU_FLAG_Z];       // RL5
            `CBSU_OP_CARRY_SET:   taken = status_flags_register_in[`CBSU_FLAG_C];        // RL6
            `CBSU_OP_CARRY_CLEAR: taken = ~status_flags_register_in[`CBSU_FLAG_C];       // RL7
            `CBSU_OP_MINUS:       taken = status_flags_register_in[`CBSU_FLAG_N];        // RL8
            `CBSU_OP_PLUS:        taken = ~status_flags_register_in[`CBSU_FLAG_N];       // RL9
            default:              taken = 1'b0;
        endcase
        if (taken && op_class == `CBSU_OP_SKIP_IO) begin
            if (next_two_word) begin
                target_pc = instr_pc + `CBSU_STEP_THREE; // RL14
                cycles    = `CBSU_CYC_THREE;
            end else begin
                target_pc = instr_pc + `CBSU_STEP_TWO; // RL14
                cycles    = `CBSU_CYC_TWO;
            end
        end else if (taken) begin
            target_pc = instr_pc + k_ext + `CBSU_STEP_ONE; // RL13
            cycles    = `CBSU_CYC_TWO; // RL11
        end
    end

endmodule

// [src/cbsu_defs.vh]
/*
 * Constants of the conditional branch and skip unit: opcode patterns,
 * decoded instruction classes, flag positions, cycle counts, register map.
 * Assumes inclusion by the unit's design files and its bench.
 */
// What this block does
// RL1: If bit b of I/O register P is one, skip the next instruction.
// RL2: Flag-set branch: if status bit s is one, PC becomes PC+k+1.
// RL3: Flag-clear branch: if status bit s is zero, PC becomes PC+k+1.
// RL4: Branch-equal jumps to PC+k+1 only when zero flag is one.
// RL5: Branch-not-equal jumps to PC+k+1 only when zero flag is zero.
// RL6: Carry-set and lower branches jump when carry flag is one.
// RL7: Carry-clear and same-or-higher branches jump when carry flag is zero.
// RL8: Branch-minus jumps when negative flag is one, else falls through.
// RL9: Branch-plus jumps when negative flag is zero, else falls through.
// RL10: No skip or branch instruction alters any status flag.
// RL11: Branches take one cycle when not taken, two when taken.
// RL12: Named branches decode as distinct classes sharing displacement k.
// RL13: Displacement k is signed, sign-extended, reaching backward or forward.
// RL14: Skip advances three words over a two-word instruction, else two.
`ifndef CBSU_DEFS_VH
`define CBSU_DEFS_VH

// Opcode patterns
`define CBSU_SKIP_MASK      16'hff00
`define CBSU_SKIP_VAL       16'h9b00
`define CBSU_BR_MASK        16'hfc00
`define CBSU_BRSET_VAL      16'hf000
`define CBSU_BRCLR_VAL      16'hf400

// Operand fields
`define CBSU_K_MSB          9
`define CBSU_K_LSB          3
`define CBSU_S_MSB          2
`define CBSU_S_LSB          0
`define CBSU_B_MSB          2
`define CBSU_B_LSB          0

// Status flag positions
`define CBSU_FLAG_C         3'h0
`define CBSU_FLAG_Z         3'h1
`define CBSU_FLAG_N         3'h2

// Decoded instruction classes
`define CBSU_OP_NONE        4'h0
`define CBSU_OP_SKIP_IO     4'h1
`define CBSU_OP_FLAG_SET    4'h2
`define CBSU_OP_FLAG_CLEAR  4'h3
`define CBSU_OP_EQUAL       4'h4
`define CBSU_OP_NOT_EQUAL   4'h5
`define CBSU_OP_CARRY_SET   4'h6
`define CBSU_OP_CARRY_CLEAR 4'h7
`define CBSU_OP_MINUS       4'h8
`define CBSU_OP_PLUS        4'h9

// Cycle counts and program counter steps
`define CBSU_CYC_ONE        2'h1
`define CBSU_CYC_TWO        2'h2
`define CBSU_CYC_THREE      2'h3
`define CBSU_STEP_ONE       16'h0001
`define CBSU_STEP_TWO       16'h0002
`define CBSU_STEP_THREE     16'h0003

// Register map
`define CBSU_REG_CTRL       4'h0
`define CBSU_REG_STATUS     4'h1
`define CBSU_REG_PC_LO      4'h2
`define CBSU_REG_PC_HI      4'h3
`define CBSU_REG_TAKEN      4'h4
`define CBSU_REG_FALL       4'h5
`define CBSU_REG_BITCNT     4'h8
`define CBSU_CTRL_RST       8'h01
`define CBSU_CTRL_EN        0
`define CBSU_CTRL_CLR       1

`endif

// [src/cbsu_unit.v]
/*
 * Conditional branch and skip unit: takes one instruction from the fetch
 * stage, holds it for its execution cycles and hands the next program
 * counter back, leaving the status flags untouched.
 * Assumes the fetch stage presents the instruction, its address, the flags,
 * the addressed I/O register value and the length of the following
 * instruction together with instr_valid, synchronous to ref_clk.
 */
`timescale 1ns/1ps
`include "cbsu_defs.vh"

module cbsu_unit (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst_n,
    // Instruction from fetch
    input  wire        instr_valid,
    input  wire [15:0] instr_word,
    input  wire [15:0] instr_pc,
    input  wire        next_two_word,
    input  wire [7:0]  io_rdata,
    input  wire [7:0]  status_flags_register_in,
    output reg         instr_ready_r,
    // Result to program counter
    output reg         done_r,
    output reg  [15:0] pc_next_r,
    output reg         taken_r,
    output reg  [1:0]  cycles_r,
    output reg  [3:0]  op_class_r,
    output reg  [7:0]  status_flags_register_out_r,
    // Register port
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata_r
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_BUSY = 2'b10;

    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [1:0]  cnt_r;
    reg  [15:0] pc_hold_r;
    reg         taken_hold_r;
    reg  [1:0]  cyc_hold_r;
    reg  [3:0]  class_hold_r;
    reg  [7:0]  status_flags_register_hold_r;
    reg  [7:0]  ctrl_r;
    reg  [7:0]  taken_cnt_r;
    reg  [7:0]  fall_cnt_r;
    reg  [7:0]  reg_rdata_nxt;

    wire [3:0]  dec_class;
    wire        dec_taken;
    wire [15:0] dec_target;
    wire [1:0]  dec_cycles;
    wire        accept;
    wire        finish;
    wire        clr_cnt;
    wire        flag_branch;
    wire [63:0] bit_cnt_flat;

    assign accept  = instr_valid & instr_ready_r;
    assign finish  = state_r[1] & (cnt_r == 2'h1);
    assign clr_cnt = reg_wr & (reg_addr == `CBSU_REG_CTRL) & reg_wdata[`CBSU_CTRL_CLR];
    assign flag_branch = (dec_class != `CBSU_OP_NONE) && (dec_class != `CBSU_OP_SKIP_IO);

    cbsu_cond u_cond (
        .instr_word    (instr_word),
        .instr_pc      (instr_pc),
        .status_flags_register_in       (status_flags_register_in),
        .io_rdata      (io_rdata),
        .next_two_word (next_two_word),
        .op_class      (dec_class),
        .taken         (dec_taken),
        .target_pc     (dec_target),
        .cycles        (dec_cycles)
    );

    // Next state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    state_nxt = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (finish) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Execution timing and result hold
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r       <= ST_IDLE;
            cnt_r         <= 2'h0;
            pc_hold_r     <= 16'h0000;
            taken_hold_r  <= 1'b0;
            cyc_hold_r    <= 2'h0;
            class_hold_r  <= 4'h0;
            status_flags_register_hold_r   <= 8'h00;
            instr_ready_r <= 1'b0;
            done_r        <= 1'b0;
            pc_next_r     <= 16'h0000;
            taken_r       <= 1'b0;
            cycles_r      <= 2'h0;
            op_class_r    <= 4'h0;
            status_flags_register_out_r    <= 8'h00;
        end else begin
            state_r       <= state_nxt;
            done_r        <= finish;
            instr_ready_r <= ctrl_r[`CBSU_CTRL_EN] & state_nxt[0];
            if (accept) begin
                cnt_r        <= dec_cycles; // RL11
                pc_hold_r    <= dec_target;
                taken_hold_r <= dec_taken;
                cyc_hold_r   <= dec_cycles;
                class_hold_r <= dec_class;
                status_flags_register_hold_r  <= status_flags_register_in; // RL10
            end else if (state_r[1]) begin
                cnt_r <= cnt_r - 2'h1;
            end
            if (finish) begin
                pc_next_r  <= pc_hold_r;
                taken_r    <= taken_hold_r;
                cycles_r   <= cyc_hold_r;
                op_class_r <= class_hold_r;
                status_flags_register_out_r <= status_flags_register_hold_r; // RL10
            end
        end
    end

    // Control register and outcome counters
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r      <= `CBSU_CTRL_RST;
            taken_cnt_r <= 8'h00;
            fall_cnt_r  <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == `CBSU_REG_CTRL) begin
                ctrl_r <= {7'h00, reg_wdata[`CBSU_CTRL_EN]};
            end
            if (accept && dec_taken) begin
                taken_cnt_r <= taken_cnt_r + 8'h01;
            end else if (clr_cnt) begin
                taken_cnt_r <= 8'h00;
            end
            if (accept && !dec_taken) begin
                fall_cnt_r <= fall_cnt_r + 8'h01;
            end else if (clr_cnt) begin
                fall_cnt_r <= 8'h00;
            end
        end
    end

    // Taken-branch count for each selected status bit
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_bitcnt
            reg [7:0] cnt_bit_r;
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_bit_r <= 8'h00;
                end else if (accept && dec_taken && flag_branch &&
                             instr_word[`CBSU_S_MSB:`CBSU_S_LSB] == gi) begin
                    cnt_bit_r <= cnt_bit_r + 8'h01;
                end else if (clr_cnt) begin
                    cnt_bit_r <= 8'h00;
                end
            end
            assign bit_cnt_flat[gi*8 +: 8] = cnt_bit_r;
        end
    endgenerate

    // Read mux
    always @* begin
        reg_rdata_nxt = 8'h00;
        if (reg_addr[3]) begin
            reg_rdata_nxt = bit_cnt_flat[reg_addr[2:0]*8 +: 8];
        end else begin
            case (reg_addr)
                `CBSU_REG_CTRL:   reg_rdata_nxt = ctrl_r;
                `CBSU_REG_STATUS: reg_rdata_nxt = {2'h0, cycles_r,
                                                   op_class_r == `CBSU_OP_SKIP_IO,
                                                   taken_r, state_r[1], 1'b0};
                `CBSU_REG_PC_LO:  reg_rdata_nxt = pc_next_r[7:0];
                `CBSU_REG_PC_HI:  reg_rdata_nxt = pc_next_r[15:8];
                `CBSU_REG_TAKEN:  reg_rdata_nxt = taken_cnt_r;
                `CBSU_REG_FALL:   reg_rdata_nxt = fall_cnt_r;
                default:          reg_rdata_nxt = 8'h00;
            endcase
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_r <= reg_rdata_nxt;
        end else begin
            reg_rdata_r <= 8'h00;
        end
    end

endmodule

// [verif/cbsu_fetch_model.sv]
/* Fetch stage model: offers one instruction and holds it until taken or for at most eight clock edges.
   Assumes the unit samples instr_valid and instr_ready_r at ref_clk rise. */
`timescale 1ns/1ps
module cbsu_fetch_model (
    // Clock and handshake
    input  wire        ref_clk,
    input  wire        instr_ready_r,
    // Instruction
    output reg         instr_valid,
    output reg  [15:0] instr_word,
    output reg  [15:0] instr_pc,
    output reg  [7:0]  status_flags_register_in,
    output reg  [7:0]  io_rdata,
    output reg         next_two_word
);
    integer n;
    initial begin
        {instr_valid, instr_word, instr_pc, status_flags_register_in, io_rdata, next_two_word} = 50'h0;
    end
    task offer(input [15:0] w, input [15:0] pc, input [7:0] f, input [7:0] io,
               input two, output ok);
        begin
            ok = 1'b0;
            @(posedge ref_clk);
            {instr_valid, instr_word, instr_pc, status_flags_register_in, io_rdata, next_two_word} <=
                {1'b1, w, pc, f, io, two};
            for (n = 0; n < 8 && !ok; n = n + 1) begin
                @(posedge ref_clk);
                ok = (instr_ready_r === 1'b1);
            end
            // Released lines stop showing the last value
            {instr_valid, instr_word, instr_pc, status_flags_register_in, io_rdata, next_two_word} <=
                {1'b0, ~w, ~pc, ~f, ~io, ~two};
        end
    endtask
endmodule

// [verif/cbsu_unit_asserts.sv]
/* Port checker of the branch and skip unit.
   Assumes it is bound to cbsu_unit and sees its ports only. */
`timescale 1ns/1ps
module cbsu_unit_asserts (
    // Clock and reset
    input wire        ref_clk,
    input wire        rst_n,
    // Instruction
    input wire        instr_valid,
    input wire [15:0] instr_word,
    input wire [15:0] instr_pc,
    input wire        next_two_word,
    input wire [7:0]  io_rdata,
    input wire [7:0]  status_flags_register_in,
    input wire        instr_ready_r,
    // Result
    input wire        done_r,
    input wire [15:0] pc_next_r,
    input wire        taken_r,
    input wire [1:0]  cycles_r,
    input wire [3:0]  op_class_r,
    input wire [7:0]  status_flags_register_out_r
);
    reg  [15:0] w_c;
    reg  [15:0] pc_c;
    reg  [7:0]  f_c;
    reg  [7:0]  io_c;
    reg         two_c;
    reg  [2:0]  cnt_c;
    wire        acc = instr_valid && instr_ready_r;
    wire [15:0] tgt = pc_c + {{9{w_c[9]}}, w_c[9:3]} + 16'h0001;
    // Capture of the accepted instruction and cycles since
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {w_c, pc_c, f_c, io_c, two_c} <= 49'h0;
            cnt_c <= 3'h0;
        end else if (acc) begin
            {w_c, pc_c, f_c, io_c, two_c} <=
                {instr_word, instr_pc, status_flags_register_in, io_rdata, next_two_word};
            cnt_c <= 3'h1;
        end else if (cnt_c != 3'h7) begin
            cnt_c <= cnt_c + 3'h1;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_ready_drops: assert property (acc |=> !instr_ready_r)
        else $error("ready held after accept");
    a_answer_time: assert property (done_r |-> cnt_c == {1'b0, cycles_r} + 3'h1)
        else $error("done not after stated cycles");
    a_branch_cycles: assert property (done_r && op_class_r > 4'h1 |->
        cycles_r == {taken_r, !taken_r})
        else $error("branch cycle count");
    a_branch_target: assert property (done_r && op_class_r > 4'h1 |->
        pc_next_r == (taken_r ? tgt : pc_c + 16'h0001))
        else $error("branch target");
    a_skip_step: assert property (done_r && op_class_r == 4'h1 |->
        cycles_r == (!taken_r ? 2'h1 : two_c ? 2'h3 : 2'h2) &&
        pc_next_r == pc_c + {14'h0, cycles_r})
        else $error("skip step");
    a_skip_cond: assert property (done_r && op_class_r == 4'h1 |->
        taken_r == io_c[w_c[2:0]])
        else $error("skip condition");
    a_named_cond: assert property (done_r && op_class_r > 4'h3 |-> taken_r ==
        (f_c[op_class_r[3] ? 2 : op_class_r[1] ? 0 : 1] ^ op_class_r[0]))
        else $error("named branch condition");
    a_flag_cond: assert property (done_r && op_class_r[3:1] == 3'h1 |->
        taken_r == (f_c[w_c[2:0]] ^ op_class_r[0]))
        else $error("flag branch condition");
    a_flags_kept: assert property (done_r |-> status_flags_register_out_r == f_c)
        else $error("flags altered");
    a_equal_class: assert property (done_r && w_c[15:11] == 5'h1e && w_c[2:0] == 3'h1 |->
        op_class_r == {3'h2, w_c[10]})
        else $error("equal class decode");
endmodule
bind cbsu_unit cbsu_unit_asserts u_asserts (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .instr_valid   (instr_valid),
    .instr_word    (instr_word),
    .instr_pc      (instr_pc),
    .next_two_word (next_two_word),
    .io_rdata      (io_rdata),
    .status_flags_register_in       (status_flags_register_in),
    .instr_ready_r (instr_ready_r),
    .done_r        (done_r),
    .pc_next_r     (pc_next_r),
    .taken_r       (taken_r),
    .cycles_r      (cycles_r),
    .op_class_r    (op_class_r),
    .status_flags_register_out_r    (status_flags_register_out_r)
);

// [verif/cbsu_unit_bench.sv]
/* Self-checking bench of the branch and skip unit.
   Assumes the fetch model drives the instruction side. */
`timescale 1ns/1ps
`include "cbsu_defs.vh"
`define CBSU_CHECK(nm, e, g) \
    begin \
        total_checks = total_checks + 1; \
        if ((g) !== (e)) begin \
            failures = failures + 1; \
            $display("wrong value %s expected %h seen %h", nm, e, g); \
        end \
    end
module cbsu_unit_bench;
    reg         ref_clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [7:0]  reg_wdata = 8'h00;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    wire        instr_valid, next_two_word, instr_ready_r, done_r, taken_r;
    wire [15:0] instr_word, instr_pc, pc_next_r;
    wire [7:0]  io_rdata, status_flags_register_in, status_flags_register_out_r, reg_rdata_r;
    wire [1:0]  cycles_r;
    wire [3:0]  op_class_r;
    integer     failures = 0;
    integer     total_checks = 0;
    reg         ok;
    reg  [7:0]  rd;
    always #12.5 ref_clk = ~ref_clk;
    cbsu_fetch_model fetch (.ref_clk(ref_clk), .instr_ready_r(instr_ready_r),
        .instr_valid(instr_valid), .instr_word(instr_word), .instr_pc(instr_pc),
        .status_flags_register_in(status_flags_register_in), .io_rdata(io_rdata), .next_two_word(next_two_word));
    cbsu_unit DUT (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_pc(instr_pc), .next_two_word(next_two_word),
        .io_rdata(io_rdata), .status_flags_register_in(status_flags_register_in), .instr_ready_r(instr_ready_r),
        .done_r(done_r), .pc_next_r(pc_next_r), .taken_r(taken_r), .cycles_r(cycles_r),
        .op_class_r(op_class_r), .status_flags_register_out_r(status_flags_register_out_r), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));
    task complete_run;
        begin
            $display("checks %0d failures %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    task reg_write(input [3:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
            @(posedge ref_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task reg_read(input [3:0] a, output [7:0] d);
        begin
            @(posedge ref_clk);
            {reg_addr, reg_rd} <= {a, 1'b1};
            @(posedge ref_clk);
            reg_rd <= 1'b0;
            @(posedge ref_clk);
            d = reg_rdata_r;
        end
    endtask
    task run(input [15:0] w, input [15:0] pc, input [7:0] f, input [7:0] io, input two,
             input [15:0] epc, input et, input [1:0] ec, input [3:0] ecl);
        reg [2:0] n;
        begin
            fetch.offer(w, pc, f, io, two, ok);
            n = 3'h0;
            repeat (6) if (ok && done_r !== 1'b1) begin
                @(posedge ref_clk);
                n = n + 3'h1;
            end
            if (done_r !== 1'b1) begin
                failures = failures + 1;
                complete_run;
            end
            `CBSU_CHECK("latency", {1'b0, ec}, n - 3'h1)
            `CBSU_CHECK("pc_next", epc, pc_next_r)
            `CBSU_CHECK("taken", et, taken_r)
            `CBSU_CHECK("cycles", ec, cycles_r)
            `CBSU_CHECK("class", ecl, op_class_r)
            `CBSU_CHECK("flags", f, status_flags_register_out_r)
        end
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reg_read(`CBSU_REG_CTRL, rd);
        `CBSU_CHECK("ctrl", 8'h01, rd)
        run(16'h9b2b, 16'h0100, 8'h00, 8'h08, 1'b0, 16'h0102, 1'b1, 2'h2, 4'h1);
        run(16'h9b2b, 16'h0100, 8'h00, 8'h08, 1'b1, 16'h0103, 1'b1, 2'h3, 4'h1);
        run(16'h9b2b, 16'h0100, 8'h00, 8'hf7, 1'b1, 16'h0101, 1'b0, 2'h1, 4'h1);
        run(16'hf00f, 16'h0500, 8'h7f, 8'h00, 1'b0, 16'h0501, 1'b0, 2'h1, 4'h2);
        run(16'hf40f, 16'h0500, 8'h7f, 8'h00, 1'b0, 16'h0502, 1'b1, 2'h2, 4'h3);
        run(16'hf3f9, 16'h0300, 8'h02, 8'h00, 1'b0, 16'h0300, 1'b1, 2'h2, 4'h4);
        run(16'hf7f9, 16'h0300, 8'h02, 8'h00, 1'b0, 16'h0301, 1'b0, 2'h1, 4'h5);
        run(16'hf409, 16'hffff, 8'h00, 8'h00, 1'b0, 16'h0001, 1'b1, 2'h2, 4'h5);
        run(16'hf1f8, 16'h0000, 8'h01, 8'h00, 1'b0, 16'h0040, 1'b1, 2'h2, 4'h6);
        run(16'hf1f8, 16'h0000, 8'hfe, 8'h00, 1'b0, 16'h0001, 1'b0, 2'h1, 4'h6);
        run(16'hf600, 16'h0010, 8'h00, 8'h00, 1'b0, 16'hffd1, 1'b1, 2'h2, 4'h7);
        run(16'hf600, 16'h0010, 8'h01, 8'h00, 1'b0, 16'h0011, 1'b0, 2'h1, 4'h7);
        run(16'hf012, 16'h0400, 8'h04, 8'h00, 1'b0, 16'h0403, 1'b1, 2'h2, 4'h8);
        run(16'hf412, 16'h0400, 8'h04, 8'h00, 1'b0, 16'h0401, 1'b0, 2'h1, 4'h9);
        run(16'hf412, 16'h0400, 8'hfb, 8'h00, 1'b0, 16'h0403, 1'b1, 2'h2, 4'h9);
        run(16'h0000, 16'h0400, 8'h55, 8'h00, 1'b0, 16'h0401, 1'b0, 2'h1, 4'h0);
        $display("test decode done");
        reg_write(`CBSU_REG_CTRL, 8'h03);
        run(16'hf025, 16'h0200, 8'h20, 8'h00, 1'b0, 16'h0205, 1'b1, 2'h2, 4'h2);
        run(16'hf425, 16'h0200, 8'h20, 8'h00, 1'b0, 16'h0201, 1'b0, 2'h1, 4'h3);
        reg_read(`CBSU_REG_TAKEN, rd);
        `CBSU_CHECK("taken count", 8'h01, rd)
        reg_read(`CBSU_REG_FALL, rd);
        `CBSU_CHECK("fall count", 8'h01, rd)
        reg_read(`CBSU_REG_BITCNT + 4'h5, rd);
        `CBSU_CHECK("bit count", 8'h01, rd)
        reg_read(`CBSU_REG_PC_LO, rd);
        `CBSU_CHECK("pc low", 8'h01, rd)
        reg_read(`CBSU_REG_PC_HI, rd);
        `CBSU_CHECK("pc high", 8'h02, rd)
        reg_read(`CBSU_REG_STATUS, rd);
        `CBSU_CHECK("status", 8'h10, rd)
        reg_write(4'h6, 8'h5a);
        reg_read(4'h6, rd);
        `CBSU_CHECK("unmapped", 8'h00, rd)
        $display("test registers done");
        reg_write(`CBSU_REG_CTRL, 8'h00);
        fetch.offer(16'hf025, 16'h0200, 8'h20, 8'h00, 1'b0, ok);
        `CBSU_CHECK("refused", 1'b0, ok)
        reg_write(`CBSU_REG_CTRL, 8'h01);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        `CBSU_CHECK("reset ready", 1'b0, instr_ready_r)
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        run(16'h9b2b, 16'h0100, 8'h00, 8'h08, 1'b1, 16'h0103, 1'b1, 2'h3, 4'h1);
        reg_read(`CBSU_REG_STATUS, rd);
        `CBSU_CHECK("status skip", 8'h3c, rd)
        $display("test disable and reset done");
        complete_run;
    end
endmodule
